// [hw/pulse_count_led_dimmer.sv]
`timescale 1ns/100ps
`default_nettype none

// How it works
// R01 - Host keeps at least 300 ns between pulses on either dimming line.
// R02 - Pulse trains from 5 kHz to 1 MHz are counted without loss.
// R03 - Device-on low for 1.5 ms enters shutdown, currents off, codes cleared.
// R04 - While device-on is low, dimming edges are ignored and codes hold.
// R05 - A channel tied to the pump output node is disabled on its own.
// R06 - Thermal trip turns outputs off; cooling by about 20 degrees resumes.
// R07 - Single-wire host drives all three lines as one common signal.
// R08 - Single-wire: first falling pulse after enable sets full scale.
// R09 - Single-wire host keeps each low phase under 0.5 ms.
// R10 - Single-wire: each later pulse lowers current by one 1 mA step.
// R11 - Single-wire host holds common line low over 1.5 ms to shut down.
// R12 - First enable leaves every channel at zero until a pulse arrives.
// R13 - First edge gives 31 mA, then minus 1 mA, 32nd zero, next 31.
// R14 - Primary line drives four primary channels, secondary line two, independently.
// R15 - Inputs synchronised, falling edges detected, shutdown timed by counter.
module pulse_count_led_dimmer
#(
    parameter int unsigned SHUTDOWN_CYCLES_P = led_dimmer_pkg::SHUTDOWN_CYCLES
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic                      device_on,
    input  wire logic                      primary_dim_line_n,
    input  wire logic                      secondary_dim_line_n,
    input  wire logic [3:0]                primary_tied_to_pump,
    input  wire logic [1:0]                secondary_tied_to_pump,
    input  wire logic                      temp_over_trip,
    input  wire logic                      temp_below_release,
    output var  led_dimmer_pkg::led_drive_t  drive_q,
    output var  led_dimmer_pkg::dev_status_t status_q
);
    import led_dimmer_pkg::*;

    // Next dimming code: any nonzero level steps down, zero wraps to full scale
    function automatic logic [4:0] next_code(input logic [4:0] code);
        next_code = (code == CODE_OFF) ? CODE_FULL_SCALE : code - 5'h01;
    endfunction

    logic [2:0]           on_sync_q;
    logic [2:0]           pri_sync_q;
    logic [2:0]           sec_sync_q;
    logic [LOW_CNT_W-1:0] low_cnt_q;
    logic [LOW_CNT_W-1:0] low_cnt_d;
    logic                 shutdown_q;
    logic                 hot_q;
    logic [4:0]           pri_code_q;
    logic [4:0]           pri_code_d;
    logic [4:0]           sec_code_q;
    logic [4:0]           sec_code_d;
    led_drive_t           drive_d;
    dev_status_t          status_d;

    localparam logic [LOW_CNT_W-1:0] LOW_LIMIT = LOW_CNT_W'(SHUTDOWN_CYCLES_P - 1);

    // Two-stage synchronisers plus one stage for edge detection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            on_sync_q  <= 3'h0;
            pri_sync_q <= 3'h7;
            sec_sync_q <= 3'h7;
        end else begin
            on_sync_q  <= {on_sync_q[1:0], device_on};        // R15
            pri_sync_q <= {pri_sync_q[1:0], primary_dim_line_n};
            sec_sync_q <= {sec_sync_q[1:0], secondary_dim_line_n};
        end
    end

    // Synchronised levels and edge events
    wire logic on_now   = on_sync_q[1];
    wire logic on_prev  = on_sync_q[2];
    // Edges are qualified by device-on as it stood before the edge, so a
    // tied single-wire falling edge still counts while a low enable blocks it
    wire logic pri_fall = pri_sync_q[2] & ~pri_sync_q[1] & on_prev & ~shutdown_q; // R04 R15 R02
    wire logic sec_fall = sec_sync_q[2] & ~sec_sync_q[1] & on_prev & ~shutdown_q; // R04 R15 R02
    wire logic low_hit  = ~on_now & ~shutdown_q & (low_cnt_q == LOW_LIMIT);       // R03

    // Low-time counter runs only while device-on is low and not yet shut down
    assign low_cnt_d = (on_now || shutdown_q) ? '0 : low_cnt_q + LOW_CNT_W'(1);   // R15

    // Per-group code update, each line owns its own counter
    assign pri_code_d = low_hit ? CODE_OFF                                      // R03
                      : pri_fall ? next_code(pri_code_q) : pri_code_q;          // R13 R14 R08 R10
    assign sec_code_d = low_hit ? CODE_OFF                                      // R03
                      : sec_fall ? next_code(sec_code_q) : sec_code_q;          // R13 R14

    // Enable state and counter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_q  <= '0;
            shutdown_q <= SHUTDOWN_RESET;
        end else begin
            low_cnt_q  <= low_cnt_d;
            shutdown_q <= low_hit | (shutdown_q & ~on_now);                     // R03 R12
        end
    end

    // Dimming codes; zero until the first pulse after enable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pri_code_q <= CODE_OFF;                                             // R12
            sec_code_q <= CODE_OFF;
        end else begin
            pri_code_q <= pri_code_d;
            sec_code_q <= sec_code_d;
        end
    end

    // Thermal hysteresis: trip wins over release
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hot_q <= HOT_RESET;
        end else begin
            hot_q <= temp_over_trip | (hot_q & ~temp_below_release);            // R06
        end
    end

    // Channel enables: live group, not hot, nonzero code, not tied to pump node
    wire logic run_ok  = ~shutdown_q & ~hot_q;                                  // R06
    wire logic pri_on  = run_ok & (pri_code_q != CODE_OFF);
    wire logic sec_on  = run_ok & (sec_code_q != CODE_OFF);

    always_comb begin
        drive_d.primary_code   = pri_code_q;
        drive_d.secondary_code = sec_code_q;
        drive_d.primary_en     = {4{pri_on}} & ~primary_tied_to_pump;           // R05 R14
        drive_d.secondary_en   = {2{sec_on}} & ~secondary_tied_to_pump;         // R05 R14
        status_d.enabled       = ~shutdown_q;
        status_d.shutdown      = shutdown_q;
        status_d.thermal_off   = hot_q;
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_q  <= '0;
            status_q <= '{enabled: 1'b0, shutdown: SHUTDOWN_RESET, thermal_off: HOT_RESET};
        end else begin
            drive_q  <= drive_d;
            status_q <= status_d;
        end
    end

    // Checks
    chk_shutdown_entry: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        low_hit |=> shutdown_q && pri_code_q == CODE_OFF && sec_code_q == CODE_OFF)
        else $error("shutdown not entered after long low");

    chk_no_early_shutdown: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        on_now && !shutdown_q |=> !shutdown_q)
        else $error("shutdown entered while device-on high");

    chk_edges_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
        !on_prev && !low_hit |=> $stable(pri_code_q) && $stable(sec_code_q))
        else $error("code changed while device-on low");

    chk_unused_channel: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        1'b1 |=> ((drive_q.primary_en & $past(primary_tied_to_pump)) == 4'h0)
              && ((drive_q.secondary_en & $past(secondary_tied_to_pump)) == 2'h0))
        else $error("tied channel enabled");

    chk_thermal_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
        temp_over_trip |=> hot_q ##1 (drive_q.primary_en == 4'h0 && drive_q.secondary_en == 2'h0))
        else $error("thermal trip did not disable channels");

    chk_thermal_resume: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
        hot_q && temp_below_release && !temp_over_trip |=> !hot_q)
        else $error("thermal shutdown not released");

    chk_first_full: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        pri_fall && pri_code_q == CODE_OFF && !low_hit |=> pri_code_q == CODE_FULL_SCALE)
        else $error("first pulse did not give full scale");

    chk_step_down: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
        pri_fall && pri_code_q != CODE_OFF |=> pri_code_q == $past(pri_code_q) - 5'h01)
        else $error("pulse did not step code down by one");

    chk_enable_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
        shutdown_q |-> pri_code_q == CODE_OFF && sec_code_q == CODE_OFF)
        else $error("nonzero code during shutdown");

    chk_group_indep: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
        pri_fall && !sec_fall && !low_hit |=> $stable(sec_code_q))
        else $error("primary pulse changed secondary code");

    chk_edge_detect: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
        $fell(pri_sync_q[1]) && on_prev && !shutdown_q && !low_hit
        |=> pri_code_q != $past(pri_code_q))
        else $error("synchronised falling edge not counted");

    // Secondary group follows the same code sequence as the primary one
    chk_sec_first: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
        sec_fall && sec_code_q == CODE_OFF && !low_hit |=> sec_code_q == CODE_FULL_SCALE)
        else $error("first secondary pulse did not give full scale");

    chk_sec_step: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
        sec_fall && sec_code_q != CODE_OFF |=> sec_code_q == $past(sec_code_q) - 5'h01)
        else $error("secondary pulse did not step code down by one");

    // Shutdown darkens every sink and shows on the status word one edge later
    chk_shutdown_dark: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        shutdown_q |=> drive_q.primary_en == 4'h0 && drive_q.secondary_en == 2'h0
                       && status_q.shutdown)
        else $error("channel lit or status wrong during shutdown");

    chk_zero_dark: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
        pri_code_q == CODE_OFF |=> drive_q.primary_en == 4'h0 && drive_q.primary_code == CODE_OFF)
        else $error("primary channel lit at zero code");

    cov_first_pulse: cover property (@(posedge ref_clk) disable iff (!reset_n)
        pri_fall && pri_code_q == CODE_OFF);
    cov_wrap_zero: cover property (@(posedge ref_clk) disable iff (!reset_n)
        pri_fall && pri_code_q == 5'h01);
    cov_shutdown: cover property (@(posedge ref_clk) disable iff (!reset_n) low_hit);
    cov_thermal: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(hot_q));

endmodule

`default_nettype wire

// [hw/led_dimmer_pkg.sv]
package led_dimmer_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned SHUTDOWN_LOW_NS  = 1500000;  // Low time on device-on that shuts down
    localparam int unsigned SHUTDOWN_CYCLES  = (SHUTDOWN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOW_CNT_W        = 20;

    // Dimming code, in mA steps
    localparam int unsigned CODE_W           = 5;
    localparam logic [4:0]  CODE_FULL_SCALE  = 5'h1F;    // 31 mA
    localparam logic [4:0]  CODE_OFF         = 5'h00;
    localparam int unsigned PRIMARY_CHANNELS = 4;
    localparam int unsigned SECONDARY_CHANNELS = 2;

    // Reset values
    localparam logic        SHUTDOWN_RESET   = 1'b1;
    localparam logic        HOT_RESET        = 1'b0;

    // Drive state of the six current sinks
    typedef struct packed {
        logic [4:0] primary_code;
        logic [4:0] secondary_code;
        logic [3:0] primary_en;
        logic [1:0] secondary_en;
    } led_drive_t;

    // Device-level state
    typedef struct packed {
        logic enabled;
        logic shutdown;
        logic thermal_off;
    } dev_status_t;

endpackage

// [test/host_gpio_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Host GPIO model, drives the enable and dimming lines off the falling edge
module host_gpio_model (
    input  wire logic ref_clk,
    output var  logic device_on,
    output var  logic primary_dim_line_n,
    output var  logic secondary_dim_line_n
);
    logic single_wire;
    initial begin
        single_wire = 1'b0;
        device_on = 1'b0;
        primary_dim_line_n = 1'b1;
        secondary_dim_line_n = 1'b1;
    end
    // Enable level, shared by all lines in single-wire mode
    task automatic set_on(input logic v);
        @(negedge ref_clk);
        device_on = v;
        if (single_wire) begin
            primary_dim_line_n = v;
            secondary_dim_line_n = v;
        end
    endtask
    // One pulse: ch 0 primary, 1 secondary, 2 common line
    task automatic pulse(input int ch, input int lo, input int hi);
        int l;
        int h;
        l = (lo < 80) ? 80 : lo;
        h = (hi < 180) ? 180 : hi;
        @(negedge ref_clk);
        if (ch == 2) device_on = 1'b0;
        if (ch != 1) primary_dim_line_n = 1'b0;
        if (ch != 0) secondary_dim_line_n = 1'b0;
        repeat (l) @(negedge ref_clk);
        if (ch == 2) device_on = 1'b1;
        primary_dim_line_n = 1'b1;
        secondary_dim_line_n = 1'b1;
        repeat (h) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import led_dimmer_pkg::*;
    localparam int unsigned SD = 400;
    logic        ref_clk, reset_n, device_on, pri_n, sec_n, t_over, t_rel;
    logic [3:0]  tie_p;
    logic [1:0]  tie_s;
    led_drive_t  drive_q;
    dev_status_t status_q;
    int          n_fail, samples_checked, pc, sc, i, n;
    logic        hot, sd;
    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #300000;
        n_fail++;
        end_sim();
    end
    host_gpio_model i_host_gpio_model (.ref_clk(ref_clk), .device_on(device_on),
        .primary_dim_line_n(pri_n), .secondary_dim_line_n(sec_n));
    pulse_count_led_dimmer #(.SHUTDOWN_CYCLES_P(SD)) i_pulse_count_led_dimmer (
        .ref_clk(ref_clk), .reset_n(reset_n), .device_on(device_on),
        .primary_dim_line_n(pri_n), .secondary_dim_line_n(sec_n),
        .primary_tied_to_pump(tie_p), .secondary_tied_to_pump(tie_s),
        .temp_over_trip(t_over), .temp_below_release(t_rel),
        .drive_q(drive_q), .status_q(status_q));
    // Compare every output bit with the model; a zero code keeps its group dark
    task automatic check();
        logic [18:0] e;
        repeat (10) @(negedge ref_clk);
        e = {pc[4:0], sc[4:0], (hot || pc == 0) ? 4'h0 : ~tie_p,
             (hot || sc == 0) ? 2'h0 : ~tie_s, ~sd, sd, hot};
        samples_checked++;
        if ({drive_q, status_q} !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, {drive_q, status_q}, e);
        end
    endtask
    // One random legal pulse, model steps only when counts is set
    task automatic dim(input int ch, input logic counts);
        tie_p = 4'($urandom % 16);
        tie_s = 2'($urandom % 4);
        i_host_gpio_model.pulse(ch, 80 + $urandom % 40, 180 + $urandom % 40);
        if (counts && ch != 1) pc = (pc == 0) ? 31 : pc - 1;
        if (counts && ch != 0) sc = (sc == 0) ? 31 : sc - 1;
    endtask
    task automatic end_sim();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {reset_n, t_over, t_rel, tie_p, tie_s, pc, sc, hot, sd} = '0;
        n_fail = 0;
        samples_checked = 0;
        sd = 1'b1;
        void'($urandom(32503));
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1'b1;
        check();
        dim(0, 0);
        check();
        i_host_gpio_model.set_on(1'b1);
        sd = 1'b0;
        tie_p = 4'($urandom % 16);
        tie_s = 2'($urandom % 4);
        check();
        for (i = 0; i < 34; i++) begin
            dim(0, 1);
            check();
        end
        n = 1 + $urandom % 40;
        for (i = 0; i < n; i++) begin
            dim(1, 1);
            check();
        end
        i_host_gpio_model.set_on(1'b0);
        i_host_gpio_model.pulse(0, 80, 180);
        i_host_gpio_model.set_on(1'b1);
        check();
        @(negedge ref_clk) t_over = 1'b1;
        hot = 1'b1;
        check();
        @(negedge ref_clk) t_over = 1'b0;
        t_rel = 1'b1;
        hot = 1'b0;
        check();
        t_rel = 1'b0;
        @(negedge ref_clk) reset_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        {pc, sc} = {32'd0, 32'd0};
        check();
        i_host_gpio_model.set_on(1'b0);
        repeat (SD + 20) @(negedge ref_clk);
        {sd, pc, sc} = {1'b1, 32'd0, 32'd0};
        check();
        i_host_gpio_model.single_wire = 1'b1;
        i_host_gpio_model.set_on(1'b1);
        sd = 1'b0;
        check();
        n = 3 + $urandom % 5;
        for (i = 0; i < n; i++) begin
            dim(2, 1);
            check();
        end
        i_host_gpio_model.set_on(1'b0);
        repeat (SD + 20) @(negedge ref_clk);
        {sd, pc, sc} = {1'b1, 32'd0, 32'd0};
        check();
        end_sim();
    end
endmodule
`default_nettype wire
